// file: logic/shadow_params.svh
// Function
// - build-time choice of one, two, four or eight sets; highest set number reported.
// - the normal registers count as set zero.
// - plain register references go to the current set; at most eight here.
// - previous-set read and write instructions reach registers of the previous set.
// - current-set field holds the live set; previous-set field the one before entry.
// - vectored internal mode takes the set from the per-priority map.
// - other exceptions and non-vectored interrupts use the software exception-set field.
// - reset class, debug entry, bootstrap mode or exception level leave fields alone.
// - otherwise entry copies current to previous, then loads current from source.
// - interrupt, vector select, no external mode, vectored support: map entry by priority.
// - interrupt, vector select, external mode: the externally supplied set.
// - every other entry loads current from the exception-set field.
// - debug return, or return with error level set, leaves fields alone.
// - any other return without an entry in the same cycle copies previous back into current.
// - reset, soft reset and non-maskable interrupt vector to bfc00000.
// - debug vectors to bfc00480, or ff200200 with the probe trap bit set.
// - other vectors are base plus offset; base bfc00200 or programmable with top 10.
// - offset 180 for general exceptions, 200 for interrupts with vector select.
// - programmable base with vector select uses the vectored offset scheme.
// - vectored offset is 200 plus number times spacing with five zeros.
// - with exception level set every general or interrupt entry uses offset 180, fields untouched.
// - base and offset add in bits 29..0 only; top two bits pass.
// - an accepted external request captures its set into the external-set field.
`ifndef SHADOW_PARAMS_SVH
`define SHADOW_PARAMS_SVH
`define ADR_CTL 8'h00
`define ADR_MAP 8'h04
`define ADR_CFG 8'h08
`define ADR_EXCEPTION_BASE_REGISTER 8'h0c
`define ADR_VEC 8'h10
`define CTL_CSS 0
`define CTL_PSS 6
`define CTL_ESS 12
`define CTL_EXT 18
`define CTL_HSS 26
`define CFG_BEV 0
`define CFG_EXL 1
`define CFG_ERL 2
`define CFG_IV 3
`define CFG_EXTERNAL_CONTROLLER_MODE_BIT 4
`define CFG_VECTORED_INTERRUPT_SUPPORT_BIT 5
`define CFG_PROBE 6
`define CFG_IPL 8
`define CFG_VS 16
`define VEC_RESET 32'hbfc00000
`define VEC_DEBUG 32'hbfc00480
`define VEC_PROBE 32'hff200200
`define BASE_BEV 32'hbfc00200
`define EXCEPTION_BASE_REGISTER_TOP 2'h2
`define OFF_GENERAL 30'h00000180
`define OFF_INTR 30'h00000200
`define RST_BEV 1'h1
`define RST_ERL 1'h1
`define RST_VECTORED_INTERRUPT_SUPPORT_BIT 1'h1
`endif

// file: logic/shadow_pkg.sv
package shadow_pkg;
	typedef enum logic [1:0] {
		EXC_GENERAL = 2'h0,
		EXC_INTERRUPT = 2'h1,
		EXC_RESET = 2'h2,
		EXC_DEBUG = 2'h3
	} exc_kind_type;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'h1,
		BUS_ACK = 2'h2
	} bus_state_type;

	typedef struct packed {
		bus_state_type bus;
		logic ack;
		logic [31:0] rdat;
		logic [3:0] current_set_field;
		logic [3:0] previous_set_field;
		logic [3:0] exception_set_field;
		logic [3:0] ext;
		logic [31:0] map;
		logic bootstrap_vector_bit;
		logic exception_level_bit;
		logic error_level_bit;
		logic iv;
		logic external_controller_mode_bit;
		logic vectored_interrupt_support_bit;
		logic probe;
		logic [5:0] priority_level;
		logic [4:0] vs;
		logic [17:0] exception_base_register;
		logic [31:0] vec;
		logic vec_vld;
		logic [8:0] gaddr;
	} state_type;
endpackage : shadow_pkg

// file: logic/shadow_vector_select.sv
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
`include "shadow_params.svh"
module shadow_vector_select #(
	parameter int NUM_SETS = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic exc_valid_i,
	input wire shadow_pkg::exc_kind_type exc_kind_i,
	input wire logic [5:0] vec_num_i,
	input wire logic eret_i,
	input wire logic debug_return_instr_i,
	input wire logic ext_req_i,
	input wire logic [3:0] ext_set_i,
	input wire logic [4:0] gpr_idx_i,
	input wire logic prev_sel_i,
	output logic [31:0] vector_addr_o,
	output logic vector_valid_o,
	output logic [3:0] current_set_o,
	output logic [3:0] previous_set_o,
	output logic [8:0] gpr_addr_o
);
	import shadow_pkg::*;

	localparam logic [3:0] HIGHEST = 4'(NUM_SETS - 1);

	generate
		if (!(NUM_SETS == 1 || NUM_SETS == 2 || NUM_SETS == 4 || NUM_SETS == 8)) begin : g_bad_sets
			$error("NUM_SETS must be 1, 2, 4 or 8");
		end
	endgenerate

	// set counts are powers of two, so masking keeps any set number legal
	function automatic logic [3:0] setmask(input logic [3:0] v);
		setmask = v & HIGHEST;
	endfunction : setmask

	function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		wmerge = r;
	endfunction : wmerge

	state_type s_r;
	state_type s_nxt;
	logic [3:0] map_pick;

	assign map_pick = setmask(s_r.map[{s_r.priority_level[2:0], 2'h0} +: 4]);

	always_comb begin
		logic [31:0] ctl_w;
		logic [31:0] cfg_w;
		logic [31:0] eb_w;
		logic [31:0] rd;
		logic [31:0] w;
		logic [31:0] base;
		logic [29:0] off;
		logic [31:0] addr;
		logic [3:0] nset;
		logic intr;
		logic skip;
		ctl_w = 32'h0;
		cfg_w = 32'h0;
		eb_w = 32'h0;
		rd = 32'h0;
		w = 32'h0;
		base = 32'h0;
		off = 30'h0;
		addr = 32'h0;
		nset = 4'h0;
		intr = 1'b0;
		skip = 1'b0;
		s_nxt = s_r;
		s_nxt.vec_vld = 1'b0;

		ctl_w[`CTL_CSS +: 4] = s_r.current_set_field;
		ctl_w[`CTL_PSS +: 4] = s_r.previous_set_field;
		ctl_w[`CTL_ESS +: 4] = s_r.exception_set_field;
		ctl_w[`CTL_EXT +: 4] = s_r.ext;
		ctl_w[`CTL_HSS +: 4] = HIGHEST;
		cfg_w[`CFG_BEV] = s_r.bootstrap_vector_bit;
		cfg_w[`CFG_EXL] = s_r.exception_level_bit;
		cfg_w[`CFG_ERL] = s_r.error_level_bit;
		cfg_w[`CFG_IV] = s_r.iv;
		cfg_w[`CFG_EXTERNAL_CONTROLLER_MODE_BIT] = s_r.external_controller_mode_bit;
		cfg_w[`CFG_VECTORED_INTERRUPT_SUPPORT_BIT] = s_r.vectored_interrupt_support_bit;
		cfg_w[`CFG_PROBE] = s_r.probe;
		cfg_w[`CFG_IPL +: 6] = s_r.priority_level;
		cfg_w[`CFG_VS +: 5] = s_r.vs;
		eb_w = {`EXCEPTION_BASE_REGISTER_TOP, s_r.exception_base_register, 12'h0};

		case (wb_adr_i)
			`ADR_CTL: rd = ctl_w;
			`ADR_MAP: rd = s_r.map;
			`ADR_CFG: rd = cfg_w;
			`ADR_EXCEPTION_BASE_REGISTER: rd = eb_w;
			`ADR_VEC: rd = s_r.vec;
			default: rd = 32'h0;
		endcase

		// read data is captured with the request, write lands on the ack edge
		case (s_r.bus)
			BUS_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					s_nxt.ack = 1'b1;
					s_nxt.rdat = rd;
					s_nxt.bus = BUS_ACK;
				end
			end
			BUS_ACK: begin
				s_nxt.ack = 1'b0;
				s_nxt.bus = BUS_IDLE;
				if (wb_cyc_i && wb_stb_i && wb_we_i) begin
					case (wb_adr_i)
						`ADR_CTL: begin
							w = wmerge(ctl_w, wb_dat_i, wb_sel_i);
							s_nxt.exception_set_field = setmask(w[`CTL_ESS +: 4]);
							s_nxt.previous_set_field = setmask(w[`CTL_PSS +: 4]);
						end
						`ADR_MAP: s_nxt.map = wmerge(s_r.map, wb_dat_i, wb_sel_i);
						`ADR_CFG: begin
							w = wmerge(cfg_w, wb_dat_i, wb_sel_i);
							s_nxt.bootstrap_vector_bit = w[`CFG_BEV];
							s_nxt.exception_level_bit = w[`CFG_EXL];
							s_nxt.error_level_bit = w[`CFG_ERL];
							s_nxt.iv = w[`CFG_IV];
							s_nxt.external_controller_mode_bit = w[`CFG_EXTERNAL_CONTROLLER_MODE_BIT];
							s_nxt.vectored_interrupt_support_bit = w[`CFG_VECTORED_INTERRUPT_SUPPORT_BIT];
							s_nxt.probe = w[`CFG_PROBE];
							s_nxt.priority_level = w[`CFG_IPL +: 6];
							s_nxt.vs = w[`CFG_VS +: 5];
						end
						`ADR_EXCEPTION_BASE_REGISTER: begin
							w = wmerge(eb_w, wb_dat_i, wb_sel_i);
							s_nxt.exception_base_register = w[29:12];
						end
						default: begin
						end
					endcase
				end
			end
			default: begin
				s_nxt.ack = 1'b0;
				s_nxt.bus = BUS_IDLE;
			end
		endcase

		if (ext_req_i) begin
			s_nxt.ext = setmask(ext_set_i);
		end

		// vector address
		off = `OFF_GENERAL;
		if (!s_r.exception_level_bit && exc_kind_i == EXC_INTERRUPT && s_r.iv) begin
			if (s_r.bootstrap_vector_bit || s_r.vs == 5'h0) begin
				off = `OFF_INTR;
			end else begin
				off = `OFF_INTR + 30'(30'(vec_num_i) * 30'({s_r.vs, 5'h0}));
			end
		end
		base = s_r.bootstrap_vector_bit ? `BASE_BEV : {`EXCEPTION_BASE_REGISTER_TOP, s_r.exception_base_register, 12'h0};
		addr = {base[31:30], base[29:0] + off};
		if (exc_kind_i == EXC_RESET) begin
			addr = `VEC_RESET;
		end else if (exc_kind_i == EXC_DEBUG) begin
			addr = s_r.probe ? `VEC_PROBE : `VEC_DEBUG;
		end

		// shadow set selection; hardware entry beats a same-cycle software write
		intr = exc_kind_i == EXC_INTERRUPT && s_r.iv;
		if (intr && !s_r.external_controller_mode_bit && s_r.vectored_interrupt_support_bit) begin
			nset = map_pick;
		end else if (intr && s_r.external_controller_mode_bit) begin
			nset = s_r.ext;
		end else begin
			nset = s_r.exception_set_field;
		end
		skip = exc_kind_i == EXC_RESET || exc_kind_i == EXC_DEBUG || s_r.bootstrap_vector_bit || s_r.exception_level_bit;

		if (exc_valid_i) begin
			s_nxt.vec = addr;
			s_nxt.vec_vld = 1'b1;
			if (!skip) begin
				s_nxt.previous_set_field = s_r.current_set_field;
				s_nxt.current_set_field = nset;
			end
		end else if (eret_i && !s_r.error_level_bit && !debug_return_instr_i) begin
			// debug return or error level set falls through and holds both fields
			s_nxt.current_set_field = s_r.previous_set_field;
		end

		// set zero is the normal bank, so a zero set reaches it unchanged
		s_nxt.gaddr = {prev_sel_i ? s_r.previous_set_field : s_r.current_set_field, gpr_idx_i};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
			s_r.bus <= BUS_IDLE;
			s_r.bootstrap_vector_bit <= `RST_BEV;
			s_r.error_level_bit <= `RST_ERL;
			s_r.vectored_interrupt_support_bit <= `RST_VECTORED_INTERRUPT_SUPPORT_BIT;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	assign wb_dat_o = s_r.rdat;
	assign wb_ack_o = s_r.ack;
	assign vector_addr_o = s_r.vec;
	assign vector_valid_o = s_r.vec_vld;
	assign current_set_o = s_r.current_set_field;
	assign previous_set_o = s_r.previous_set_field;
	assign gpr_addr_o = s_r.gaddr;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_entry;
		exc_valid_i && ce_i && exc_kind_i inside {EXC_GENERAL, EXC_INTERRUPT} && !s_r.bootstrap_vector_bit && !s_r.exception_level_bit;
	endsequence

	sequence s_vectored_interrupt_support_bit_entry;
		s_entry and (exc_kind_i == EXC_INTERRUPT && s_r.iv);
	endsequence

	sequence s_quiet_bus;
		!wb_cyc_i && !ext_req_i;
	endsequence

	a_entry_prev_copy: assert property (s_entry |=> previous_set_o == $past(current_set_o))
		else $error("previous set not loaded from current on entry");
	a_entry_skip_hold: assert property ((exc_valid_i && ce_i && (s_r.bootstrap_vector_bit || s_r.exception_level_bit ||
		exc_kind_i inside {EXC_RESET, EXC_DEBUG})) and s_quiet_bus |=>
		$stable(current_set_o) && $stable(previous_set_o))
		else $error("set fields changed on a skipped entry");
	a_map_select: assert property (s_vectored_interrupt_support_bit_entry and (!s_r.external_controller_mode_bit && s_r.vectored_interrupt_support_bit) |=>
		current_set_o == $past(map_pick))
		else $error("vectored entry did not use the map entry");
	a_ext_select: assert property (s_vectored_interrupt_support_bit_entry and s_r.external_controller_mode_bit |=> current_set_o == $past(s_r.ext))
		else $error("external entry did not use the external set");
	a_ess_select: assert property (s_entry and !(exc_kind_i == EXC_INTERRUPT && s_r.iv) |=>
		current_set_o == $past(s_r.exception_set_field))
		else $error("exception entry did not use the exception set");
	a_ret_restore: assert property (eret_i && !debug_return_instr_i && !exc_valid_i && !s_r.error_level_bit && ce_i |=>
		current_set_o == $past(previous_set_o))
		else $error("return did not restore previous set");
	a_ret_hold: assert property ((debug_return_instr_i || (eret_i && s_r.error_level_bit)) && !exc_valid_i && ce_i and s_quiet_bus
		|=> $stable(current_set_o))
		else $error("set changed on a held return");
	a_reset_vector: assert property (exc_valid_i && ce_i && exc_kind_i == EXC_RESET |=>
		vector_valid_o && vector_addr_o == 32'hbfc00000)
		else $error("reset class vector wrong");
	a_debug_vector: assert property (exc_valid_i && ce_i && exc_kind_i == EXC_DEBUG |=>
		vector_addr_o == ($past(s_r.probe) ? 32'hff200200 : 32'hbfc00480))
		else $error("debug vector wrong");
	a_exl_general: assert property (exc_valid_i && ce_i && s_r.exception_level_bit && exc_kind_i == EXC_INTERRUPT |=>
		vector_addr_o[11:0] == ($past(s_r.bootstrap_vector_bit) ? 12'h380 : 12'h180))
		else $error("nested exception not at general offset");
	a_top_bits: assert property (exc_valid_i && ce_i && !s_r.bootstrap_vector_bit && exc_kind_i == EXC_GENERAL |=>
		vector_addr_o[31:30] == 2'h2)
		else $error("vector top bits disturbed by offset carry");
	a_ext_capture: assert property (ext_req_i && ce_i |=> s_r.ext == setmask($past(ext_set_i)))
		else $error("external set not captured");
	a_bus_answer: assert property (wb_cyc_i && wb_stb_i && ce_i && s_r.bus == BUS_IDLE |=>
		wb_ack_o ##1 (!wb_ack_o || !ce_i))
		else $error("bus answer not one cycle");

	// spaced vectored interrupt with programmable base
	sequence s_spaced_intr;
		s_entry and (exc_kind_i == EXC_INTERRUPT && s_r.iv && s_r.vs != 5'h0);
	endsequence

	sequence s_bus_take;
		wb_cyc_i && wb_stb_i && ce_i && s_r.bus == BUS_IDLE;
	endsequence

	a_vec_pulse: assert property (exc_valid_i && ce_i
		|=> vector_valid_o)
		else $error("vector valid missing after entry");
	a_vec_quiet: assert property (!exc_valid_i && ce_i
		|=> !vector_valid_o)
		else $error("vector valid without entry");
	a_cur_range: assert property (current_set_o <= HIGHEST)
		else $error("current set beyond highest set");
	a_prev_range: assert property (previous_set_o <= HIGHEST)
		else $error("previous set beyond highest set");
	a_gpr_current: assert property (ce_i && !prev_sel_i
		|=> gpr_addr_o == {$past(current_set_o), $past(gpr_idx_i)})
		else $error("register access not in current set");
	a_gpr_previous: assert property (ce_i && prev_sel_i
		|=> gpr_addr_o == {$past(previous_set_o), $past(gpr_idx_i)})
		else $error("previous set access not in previous set");
	a_base_boot: assert property (exc_valid_i && ce_i && s_r.bootstrap_vector_bit && exc_kind_i == EXC_GENERAL
		|=> vector_addr_o == 32'hbfc00380)
		else $error("bootstrap general vector wrong");
	a_plain_intr: assert property (exc_valid_i && ce_i && !s_r.exception_level_bit && exc_kind_i == EXC_INTERRUPT && s_r.iv &&
		(s_r.bootstrap_vector_bit || s_r.vs == 5'h0)
		|=> vector_addr_o == ($past(s_r.bootstrap_vector_bit) ? 32'hbfc00400 : {2'h2, $past(s_r.exception_base_register), 12'h200}))
		else $error("plain interrupt vector wrong");
	a_noiv_intr: assert property (exc_valid_i && ce_i && exc_kind_i == EXC_INTERRUPT && !s_r.iv && !s_r.bootstrap_vector_bit
		|=> vector_addr_o == {2'h2, $past(s_r.exception_base_register), 12'h180})
		else $error("non-vectored interrupt not at general offset");
	a_spaced_off: assert property (s_spaced_intr
		|=> vector_addr_o[29:0] == 30'({$past(s_r.exception_base_register), 12'h0} + 30'h200 +
		30'($past(vec_num_i)) * 30'({$past(s_r.vs), 5'h0})))
		else $error("spaced interrupt offset wrong");
	a_idle_hold: assert property (!exc_valid_i && !eret_i && ce_i and s_quiet_bus
		|=> $stable(current_set_o) && $stable(previous_set_o))
		else $error("set fields moved with no event");
	a_ret_prev_hold: assert property ((eret_i || debug_return_instr_i) && !exc_valid_i && ce_i and s_quiet_bus
		|=> $stable(previous_set_o))
		else $error("return disturbed previous set");
	a_ce_freeze: assert property (!ce_i
		|=> $stable(vector_addr_o) && $stable(current_set_o) && $stable(previous_set_o) && $stable(wb_ack_o))
		else $error("state moved with clock enable low");
	a_ext_hold: assert property (!ext_req_i && ce_i
		|=> s_r.ext == $past(s_r.ext))
		else $error("external set moved without request");
	a_ack_idle: assert property (!wb_cyc_i && s_r.bus == BUS_IDLE && ce_i
		|=> !wb_ack_o)
		else $error("ack without request");
	a_read_vec: assert property (s_bus_take and wb_adr_i == `ADR_VEC
		|=> wb_dat_o == $past(vector_addr_o))
		else $error("vector readback wrong");
	a_read_hss: assert property (s_bus_take and wb_adr_i == `ADR_CTL
		|=> wb_dat_o[29:26] == HIGHEST)
		else $error("highest set readback wrong");
	a_read_unmapped: assert property (s_bus_take and
		!(wb_adr_i inside {`ADR_CTL, `ADR_MAP, `ADR_CFG, `ADR_EXCEPTION_BASE_REGISTER, `ADR_VEC})
		|=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_exl_sets_hold: assert property (exc_valid_i && ce_i && s_r.exception_level_bit and s_quiet_bus
		|=> $stable(current_set_o) && $stable(previous_set_o))
		else $error("nested entry changed set fields");
endmodule : shadow_vector_select

// file: test/eic_model.sv
`timescale 1ns/1ns
module eic_model (
	input wire logic clk_i,
	input wire logic fire_i,
	input wire logic [3:0] set_i,
	output logic req_o,
	output logic [3:0] set_o
);
	initial begin
		req_o = 1'b0;
		set_o = 4'h0;
	end
	// idle set lines toggle so a stale number never looks valid
	always @(posedge clk_i) begin
		req_o <= fire_i;
		set_o <= fire_i ? set_i : ~set_o;
	end
endmodule : eic_model

// file: test/tb_shadow_vector_select.sv
`timescale 1ns/1ns
module tb_shadow_vector_select;
	import shadow_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc = 1'b0, we = 1'b0, xv = 1'b0, er = 1'b0, dr = 1'b0;
	logic ps = 1'b0, fire = 1'b0, xreq, ack, vvld;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, vaddr, cfg, map, exception_base_register;
	logic [3:0] fset = 4'h0, xset, current_set_field, previous_set_field, exception_set_field, ext, cur, prv;
	logic [4:0] idx = 5'h0;
	logic [5:0] vnum = 6'h0;
	logic [8:0] gaddr;
	exc_kind_type kind = EXC_GENERAL;
	integer seed = 32'h636079c1, error_cnt = 0, num_checks = 0, i;
	always #2 clk_i = ~clk_i;
	eic_model eic_model_i (.clk_i(clk_i), .fire_i(fire), .set_i(fset), .req_o(xreq), .set_o(xset));
	shadow_vector_select #(.NUM_SETS(8)) shadow_vector_select_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .exc_valid_i(xv), .exc_kind_i(kind), .vec_num_i(vnum), .eret_i(er),
		.debug_return_instr_i(dr), .ext_req_i(xreq), .ext_set_i(xset), .gpr_idx_i(idx), .prev_sel_i(ps),
		.vector_addr_o(vaddr), .vector_valid_o(vvld), .current_set_o(cur), .previous_set_o(prv), .gpr_addr_o(gaddr));
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			if (n > 20) begin
				error_cnt++;
				tally_and_finish;
			end
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	function automatic logic [31:0] vexp(input exc_kind_type k, input logic [5:0] v);
		logic [31:0] b;
		logic [29:0] o;
		if (k == EXC_RESET)
			return 32'hbfc00000;
		if (k == EXC_DEBUG)
			return cfg[6] ? 32'hff200200 : 32'hbfc00480;
		b = cfg[0] ? 32'hbfc00200 : {2'b10, exception_base_register[29:12], 12'h000};
		o = 30'h180;
		if (!cfg[1] && k == EXC_INTERRUPT && cfg[3])
			o = (cfg[0] || cfg[20:16] == 5'h0) ? 30'h200 : 30'h200 + v * {cfg[20:16], 5'h00};
		return {b[31:30], b[29:0] + o};
	endfunction : vexp
	function automatic logic [3:0] nset(input exc_kind_type k);
		if (k == EXC_INTERRUPT && cfg[3] && cfg[4])
			return ext;
		if (k == EXC_INTERRUPT && cfg[3] && cfg[5])
			return map[4 * cfg[10:8] +: 4] & 4'h7;
		return exception_set_field;
	endfunction : nset
	task automatic enter(input exc_kind_type k, input logic [5:0] v);
		logic [31:0] ev;
		logic [8:0] eg;
		ev = vexp(k, v);
		kind <= k;
		vnum <= v;
		xv <= 1'b1;
		idx <= 5'($random(seed));
		ps <= 1'($random(seed));
		@(posedge clk_i);
		eg = {ps ? previous_set_field : current_set_field, idx};
		if (k != EXC_RESET && k != EXC_DEBUG && !cfg[0] && !cfg[1]) begin
			previous_set_field = current_set_field;
			current_set_field = nset(k);
		end
		xv <= 1'b0;
		#1;
		chk(vvld, 1);
		chk(vaddr, ev);
		chk(cur, current_set_field);
		chk(prv, previous_set_field);
		chk(gaddr, eg);
	endtask : enter
	task automatic leave(input logic [1:0] m);
		@(posedge clk_i);
		er <= m[0];
		dr <= m[1];
		@(posedge clk_i);
		if (m[0] && !m[1] && !cfg[2])
			current_set_field = previous_set_field;
		er <= 1'b0;
		dr <= 1'b0;
		#1;
		chk(cur, current_set_field);
	endtask : leave
	task automatic rdctl;
		logic [31:0] q, e;
		bus(0, 8'h00, 0, q);
		e = 32'h1c000000;
		e[3:0] = current_set_field;
		e[9:6] = previous_set_field;
		e[15:12] = exception_set_field;
		e[21:18] = ext;
		chk(q, e);
	endtask : rdctl
	initial begin
		logic [31:0] q, d;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		bus(0, 8'h08, 0, q);
		chk(q, 32'h25);
		bus(0, 8'h0c, 0, q);
		chk(q, 32'h80000000);
		bus(0, 8'h14, 0, q);
		chk(q, 0);
		cfg = 32'h25;
		map = 0;
		exception_base_register = 0;
		{current_set_field, previous_set_field, exception_set_field, ext} = 16'h0;
		rdctl;
		for (i = 0; i < 300; i++) begin
			d = $random(seed);
			if (i % 2)
				d[1:0] = 2'b00;
			bus(1, 8'h08, d, q);
			cfg = d;
			d = $random(seed);
			bus(1, 8'h00, d, q);
			previous_set_field = d[9:6] & 4'h7;
			exception_set_field = d[15:12] & 4'h7;
			if (i % 4 == 0) begin
				map = $random(seed);
				bus(1, 8'h04, map, q);
				exception_base_register = $random(seed);
				bus(1, 8'h0c, exception_base_register, q);
				bus(0, 8'h0c, 0, q);
				chk(q, {2'b10, exception_base_register[29:12], 12'h000});
			end
			d = $random(seed);
			fire <= 1'b1;
			fset <= {1'b0, d[2:0]};
			@(posedge clk_i);
			fire <= 1'b0;
			@(posedge clk_i);
			ext = {1'b0, d[2:0]};
			d = $random(seed);
			enter(exc_kind_type'(d[1:0]), cfg[4] ? d[7:2] : {3'h0, d[4:2]});
			leave(d[9:8]);
			if (i % 8 == 0)
				rdctl;
		end
		// clock enable low must swallow a taken exception
		@(posedge clk_i);
		ce_i <= 1'b0;
		xv <= 1'b1;
		@(posedge clk_i);
		xv <= 1'b0;
		#1;
		chk(vvld, 0);
		chk(cur, current_set_field);
		ce_i <= 1'b1;
		tally_and_finish;
	end
endmodule : tb_shadow_vector_select
